// ==== core/usb_cmd_cfg.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the command logic
// Assumes: 10 MHz controller clock
// Notes:   included by its bare name
`ifndef USB_CMD_CFG_SVH
`define USB_CMD_CFG_SVH

`define USB_COMMAND_OFS     8'h20
`define USB_STATUS_OFS      8'h24
`define CMD_RUN_STOP_BIT    0
`define CMD_CTRL_RESET_BIT  1
`define CMD_FLS_LO_BIT      2
`define CMD_FLS_HI_BIT      3
`define STS_HALTED_BIT      12
`define FLS_RESET_VAL       2'h0
`define FLS_1024            2'h0
`define FLS_512             2'h1
`define FLS_256             2'h2
`define HALTED_RESET_VAL    1'h1
`define CTRL_RESET_NS       1600
`define CLK_PERIOD_NS       100
`define CTRL_RESET_CYCLES   ((`CTRL_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== core/usb_cmd_pkg.sv ====
// Purpose: types shared by the command register logic
// Assumes: constants live in usb_cmd_cfg.svh
// Notes:   nothing here holds a number of its own
package usb_cmd_pkg;

    // software-visible command fields
    typedef struct packed {
        logic [1:0] frame_list_size;
        logic       controller_reset;
        logic       run_stop;
    } command_t;

    // run/stop engine states
    typedef enum logic [1:0] {
        ST_HALTED,
        ST_RUNNING,
        ST_STOPPING,
        ST_RESETTING
    } ctl_state_t;

endpackage

// ==== core/usb_host_command_control.sv ====
// Purpose: command register, controller reset sequencer and run/stop handshake
// Assumes: register accesses are single-cycle strobes synchronous to ref_clk
// Notes:   frame index and pipeline status come from the schedule engine
//
// Operation
// - frame list size 00b 1024, 01b 512, 10b 256 entries; 11b reserved; resets 00b.
// - frame list size writable only when the programmable list capability flag is set.
// - chosen size picks which frame index counter bits form the list index.
// - controller reset returns pipelines, timers, counters and state machines to initial.
// - controller reset aborts current transaction at once and drives no bus reset.
// - controller reset leaves PCI configuration registers untouched.
// - controller reset restores all operational and port registers to initial values.
// - controller reset gives port ownership back to the companion controllers.
// - reset bit self-clears when done; writing zero cannot cut the reset short.
// - run/stop one keeps the schedule executing; zero requests a stop.
// - on stop the pipeline's current transactions finish before halting.
// - halted flag marks the moment outstanding work is done and stopped.
// - command register sits at offset 20h of the memory window.
// - halted reads zero while running, one after any stop; resets to one.
`timescale 1ns/1ps
`include "usb_cmd_cfg.svh"

module usb_host_command_control (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic [3:0]  reg_be,
    output logic      [31:0] reg_rdata,
    output logic             reg_ack,
    input  wire logic        programmable_list_flag,
    input  wire logic        pipeline_busy,
    input  wire logic        hw_error_stop,
    input  wire logic [13:0] frame_index,
    output logic      [9:0]  frame_list_index,
    output logic             schedule_run,
    output logic             controller_halted,
    output logic             core_reset,
    output logic             transaction_abort,
    output logic             port_to_companion
);

    // ****************************************************************
    // command register and reset sequencer
    // ****************************************************************
    // the reset sequence is timed by a down-counter loaded with RESET_LEN
    // when software sets the reset bit; the count is in controller clocks,
    // so a change of clock rate must be matched in the config header
    //
    // while the sequence runs, every command write is dropped; this is what
    // stops a write of zero from ending the reset early, and it also means
    // software cannot queue a run request behind the reset
    //
    // the halted flag is forced to its reset value at both ends of the
    // sequence so that a poll of the status word never sees a stale zero
    //
    // run/stop is a four-state engine: halted, running, stopping and resetting; the
    // stopping state keeps schedule_run high until the pipeline drains, so
    // a stop never cuts the schedule engine off in the middle of a transaction
    //
    // a hardware error stop clears run_stop exactly as a software write of
    // zero would, and then follows the same drain path before halting
    //
    // the frame list size field is only loaded when the capability input
    // allows it; the reserved code is stored as written and indexes as the
    // largest list, which is the least harmful reading of a bad value
    localparam logic [7:0] RESET_LEN = 8'(`CTRL_RESET_CYCLES);

    usb_cmd_pkg::command_t    cmd_r,    cmd_nxt;
    usb_cmd_pkg::ctl_state_t  state_r,  state_nxt;
    logic [7:0]               rst_cnt_r, rst_cnt_nxt;
    logic                     halted_r,  halted_nxt;
    logic                     cmd_wr;
    logic                     sts_wr;

    assign cmd_wr = reg_wr && (reg_addr == `USB_COMMAND_OFS) && reg_be[0];
    assign sts_wr = reg_wr && (reg_addr == `USB_STATUS_OFS);

    // next state of command fields, halted flag and run/stop engine
    always_comb begin
        cmd_nxt     = cmd_r;
        state_nxt   = state_r;
        rst_cnt_nxt = rst_cnt_r;
        halted_nxt  = halted_r;
        unique case (state_r)
            usb_cmd_pkg::ST_RESETTING: begin
                // writes are ignored here so a zero cannot end the reset early
                if (rst_cnt_r == 8'h01) begin
                    cmd_nxt     = '0;
                    cmd_nxt.frame_list_size = `FLS_RESET_VAL;
                    halted_nxt  = `HALTED_RESET_VAL;
                    state_nxt   = usb_cmd_pkg::ST_HALTED;
                    rst_cnt_nxt = 8'h00;
                end else begin
                    rst_cnt_nxt = rst_cnt_r - 8'h01;
                end
            end
            default: begin
                if (cmd_wr) begin
                    cmd_nxt.run_stop = reg_wdata[`CMD_RUN_STOP_BIT];
                    if (programmable_list_flag) begin
                        cmd_nxt.frame_list_size =
                            reg_wdata[`CMD_FLS_HI_BIT:`CMD_FLS_LO_BIT];
                    end
                end
                if (hw_error_stop) begin
                    cmd_nxt.run_stop = 1'b0;
                end
                unique case (state_r)
                    usb_cmd_pkg::ST_HALTED: begin
                        if (cmd_nxt.run_stop) begin
                            state_nxt  = usb_cmd_pkg::ST_RUNNING;
                            halted_nxt = 1'b0;
                        end
                    end
                    usb_cmd_pkg::ST_RUNNING: begin
                        if (!cmd_nxt.run_stop) begin
                            state_nxt = usb_cmd_pkg::ST_STOPPING;
                        end
                    end
                    usb_cmd_pkg::ST_STOPPING: begin
                        if (cmd_nxt.run_stop) begin
                            state_nxt = usb_cmd_pkg::ST_RUNNING;
                        end else if (!pipeline_busy) begin
                            state_nxt  = usb_cmd_pkg::ST_HALTED;
                            halted_nxt = 1'b1;
                        end
                    end
                    default: begin
                        state_nxt = usb_cmd_pkg::ST_HALTED;
                    end
                endcase
                // controller reset overrides everything else in the cycle
                if (cmd_wr && reg_wdata[`CMD_CTRL_RESET_BIT]) begin
                    cmd_nxt     = '0;
                    cmd_nxt.controller_reset = 1'b1;
                    state_nxt   = usb_cmd_pkg::ST_RESETTING;
                    rst_cnt_nxt = RESET_LEN;
                    halted_nxt  = `HALTED_RESET_VAL;
                end
            end
        endcase
    end

    // status flag has no writable bits here; writes to it are accepted and dropped
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_r     <= '0;
            state_r   <= usb_cmd_pkg::ST_HALTED;
            rst_cnt_r <= 8'h00;
            halted_r  <= `HALTED_RESET_VAL;
        end else if (ce) begin
            cmd_r     <= cmd_nxt;
            state_r   <= state_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            halted_r  <= halted_nxt;
        end
    end

    // ****************************************************************
    // outputs to the rest of the controller and read port
    // ****************************************************************
    logic [31:0] rdata_nxt;
    logic        ack_nxt;
    logic [9:0]  index_nxt;
    logic        resetting_nxt;

    // index slice follows the selected list size
    always_comb begin
        index_nxt = 10'h000;
        unique case (cmd_r.frame_list_size)
            `FLS_512: index_nxt = {1'b0, frame_index[11:3]};
            `FLS_256: index_nxt = {2'b00, frame_index[10:3]};
            default:  index_nxt = frame_index[12:3];          // reserved as 1024
        endcase
    end

    // register reads return zero in reserved and unmapped positions
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        ack_nxt   = reg_wr || reg_rd;
        if (reg_rd && reg_addr == `USB_COMMAND_OFS) begin
            rdata_nxt[`CMD_RUN_STOP_BIT]   = cmd_nxt.run_stop;
            rdata_nxt[`CMD_CTRL_RESET_BIT] = cmd_nxt.controller_reset;
            rdata_nxt[`CMD_FLS_HI_BIT:`CMD_FLS_LO_BIT] = cmd_nxt.frame_list_size;
        end else if (reg_rd && reg_addr == `USB_STATUS_OFS) begin
            rdata_nxt[`STS_HALTED_BIT] = halted_nxt;
        end
        resetting_nxt = (state_nxt == usb_cmd_pkg::ST_RESETTING);
    end

    // outputs come straight from flops; abort is a level for the whole reset
    // so the pipeline drops its transaction at once, with no bus reset driven
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata         <= 32'h0000_0000;
            reg_ack           <= 1'b0;
            frame_list_index  <= 10'h000;
            schedule_run      <= 1'b0;
            controller_halted <= `HALTED_RESET_VAL;
            core_reset        <= 1'b0;
            transaction_abort <= 1'b0;
            port_to_companion <= 1'b1;
        end else if (ce) begin
            reg_rdata         <= rdata_nxt;
            reg_ack           <= ack_nxt && !sts_wr ? 1'b1 : ack_nxt;
            frame_list_index  <= index_nxt;
            schedule_run      <= (state_nxt == usb_cmd_pkg::ST_RUNNING) ||
                                 (state_nxt == usb_cmd_pkg::ST_STOPPING);
            controller_halted <= halted_nxt;
            core_reset        <= resetting_nxt;
            transaction_abort <= resetting_nxt;
            port_to_companion <= resetting_nxt ? 1'b1 : port_to_companion;
        end
    end

endmodule

// ==== dv/usb_cmd_checker.sv ====
// Purpose: port assertions for the command, reset and run/stop logic
// Assumes: ce held high by the bench
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
module usb_cmd_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [3:0]  reg_be,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_ack,
    input wire logic        pipeline_busy,
    input wire logic        hw_error_stop,
    input wire logic        schedule_run,
    input wire logic        controller_halted,
    input wire logic        core_reset,
    input wire logic        transaction_abort,
    input wire logic        port_to_companion
);
    logic [4:0] rcnt_r;
    logic [4:0] rcnt_nxt;
    wire        cmd_wr = reg_wr && reg_addr == 8'h20 && reg_be[0];
    // cycles spent in the reset sequence; wraps only if it hangs, caught below
    always_comb rcnt_nxt = core_reset ? rcnt_r + 5'h1 : 5'h0;
    always_ff @(posedge ref_clk or posedge rst) begin
        rcnt_r <= rst ? 5'h0 : rcnt_nxt;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ***************************
    // assertions
    // ***************************
    AST_ACK: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("no ack");
    AST_NO_ACK: assert property (!(reg_wr || reg_rd) |=> !reg_ack) else $error("stray ack");
    AST_RST_GO: assert property (cmd_wr && reg_wdata[1] && !core_reset |=> core_reset
        && port_to_companion && controller_halted && !schedule_run) else $error("reset start");
    AST_RST_LEN: assert property ($fell(core_reset) |-> rcnt_r == 5'h10) else $error("reset len");
    AST_RST_MAX: assert property (core_reset |-> rcnt_r < 5'h10) else $error("reset stuck");
    AST_ABORT: assert property (transaction_abort == core_reset) else $error("abort");
    AST_RST_BIT: assert property (core_reset && rcnt_r < 5'hF && reg_rd && reg_addr == 8'h20
        |=> reg_rdata[1]) else $error("reset bit read");
    AST_RUN: assert property (cmd_wr && reg_wdata[1:0] == 2'h1 && !core_reset && !hw_error_stop
        |=> schedule_run && !controller_halted) else $error("run");
    AST_PAIR: assert property (schedule_run != controller_halted) else $error("halted");
    AST_DRAIN: assert property (schedule_run && pipeline_busy && !reg_wr |=> schedule_run)
        else $error("drain");
    AST_HALT: assert property (schedule_run && !pipeline_busy && hw_error_stop && !reg_wr
        |-> ##[1:2] controller_halted) else $error("halt");
    cover property ($fell(core_reset));
    cover property ($fell(schedule_run));
    cover property (schedule_run && pipeline_busy);
endmodule
bind usb_host_command_control usb_cmd_checker chk_i (.ref_clk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_be, .reg_rdata, .reg_ack, .pipeline_busy, .hw_error_stop,
    .schedule_run, .controller_halted, .core_reset, .transaction_abort, .port_to_companion);

// ==== dv/test_usb_host_command_control.sv ====
// Purpose: directed bench for the command register block
// Assumes: ce tied high, all byte lanes enabled
// Notes:   each access checks its ack one clock after the strobe, before the next
`timescale 1ns/1ps
module test_usb_host_command_control;
    logic        ref_clk, rst, reg_wr, reg_rd, flag, busy, hw_stop, reg_ack;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic [13:0] fidx;
    logic [9:0]  lidx;
    logic        run, halted, creset, abort, comp;
    int          failures, checks, n;
    usb_host_command_control dut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(4'hF),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .programmable_list_flag(flag),
        .pipeline_busy(busy), .hw_error_stop(hw_stop), .frame_index(fidx),
        .frame_list_index(lidx), .schedule_run(run), .controller_halted(halted),
        .core_reset(creset), .transaction_abort(abort), .port_to_companion(comp));
    // free-running 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one access; strobe dropped at the taking edge, answer read once it lands
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= w;
        reg_rd    <= !w;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
        chk("ack", 32'h1, {31'h0, reg_ack});
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk("read", exp, rd_val);
    endtask
    task automatic ticks(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_fls();
        acc(1'b1, 8'h20, 32'h8);
        rdchk(8'h20, 32'h0);
        @(posedge ref_clk);
        flag <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, 8'h20, 32'(i) << 2);
            rdchk(8'h20, 32'(i) << 2);
            ticks(2);
            chk("index", {22'h0, fidx[12:3] & (10'h3FF >> i)}, {22'h0, lidx});
        end
    endtask
    task automatic t_run();
        rdchk(8'h24, 32'h1000);
        acc(1'b1, 8'h20, 32'h9);
        ticks(1);
        chk("run", 32'h1, {31'h0, run & ~halted});
        busy <= 1'b1;
        acc(1'b1, 8'h20, 32'h8);
        ticks(3);
        chk("drain", 32'h1, {31'h0, run & ~halted});
        busy <= 1'b0;
        ticks(2);
        chk("stop", 32'h1, {31'h0, halted & ~run});
        acc(1'b1, 8'h20, 32'h9);
        hw_stop <= 1'b1;
        ticks(1);
        hw_stop <= 1'b0;
        ticks(2);
        chk("err stop", 32'h1, {31'h0, halted});
        rdchk(8'h20, 32'h8);
    endtask
    task automatic t_creset();
        acc(1'b1, 8'h20, 32'h2);
        ticks(1);
        chk("reset outs", 32'h7, {29'h0, creset, abort, comp});
        acc(1'b1, 8'h20, 32'h0);
        rdchk(8'h20, 32'h2);
        n = 0;
        while (rd_val[1] === 1'b1 && n < 20) begin
            acc(1'b0, 8'h20, 32'h0);
            n++;
        end
        chk("reset end", 32'h0, rd_val | {31'h0, creset});
        rdchk(8'h24, 32'h1000);
        acc(1'b1, 8'h20, 32'h5);
        rdchk(8'h20, 32'h5);
        ticks(1);
        chk("reinit run", 32'h1, {31'h0, run & ~halted});
        acc(1'b1, 8'h20, 32'h4);
        ticks(2);
        chk("reinit stop", 32'h1, {31'h0, halted & ~run});
    endtask
    task automatic summarize();
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard, far beyond the fewer than a hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        summarize();
    end
    initial begin
        {rst, reg_wr, reg_rd, flag, busy, hw_stop} = 6'h20;
        reg_addr  = 8'h0;
        reg_wdata = 32'h0;
        fidx      = 14'h2AB5;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rdchk(8'h20, 32'h0);
        rdchk(8'h24, 32'h1000);
        rdchk(8'h40, 32'h0);
        t_fls();
        t_run();
        t_creset();
        summarize();
    end
endmodule
